// ==== rtl/timer_q_pkg.sv ====
package timer_q_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] IOC_OFS = 8'h04;
	localparam logic [7:0] CMP0_OFS = 8'h08;
	localparam logic [7:0] CMP_STEP = 8'h04;
	localparam logic [7:0] COUNT_OFS = 8'h18;
	localparam logic [7:0] STATUS_OFS = 8'h1C;
	localparam int CMP_NUM = 4;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_TRIG_BIT = 4;
	localparam int CTRL_CAPSEL_BIT = 5;
	localparam int CTRL_CAPEDGE_LSB = 6;
	localparam int CTRL_EVTEDGE_LSB = 8;
	localparam int CTRL_OFFEDGE_LSB = 10;
	localparam int IOC_GATE_LSB = 0;
	localparam int IOC_LEVEL_LSB = 4;
	localparam int IOC_ZEROSEL_BIT = 8;

	// ****************************************
	// reset and counter values
	// ****************************************
	localparam logic [15:0] CNT_IDLE = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CMP_RESET = 16'h0000;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	typedef enum logic [2:0] {
		MODE_INTERVAL = 3'b000,
		MODE_EVENT = 3'b001,
		MODE_EXTTRIG = 3'b010,
		MODE_ONESHOT = 3'b011,
		MODE_PWM = 3'b100,
		MODE_FREERUN = 3'b101,
		MODE_PULSEWIDTH = 3'b110
	} mode_t;

	typedef enum logic [1:0] {
		EDGE_NONE = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_FALL = 2'b10,
		EDGE_BOTH = 2'b11
	} edge_sel_t;

endpackage

// ==== rtl/edge_pulse.sv ====
`timescale 1ns/10ps
module edge_pulse
	import timer_q_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic sigIn,
	input wire edge_sel_t edgeSel,
	output logic pulse
);

	typedef struct packed {
		logic prev;
		logic pulse;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.prev = sigIn;
		unique case (edgeSel)
			EDGE_NONE: s_nxt.pulse = 1'b0;
			EDGE_RISE: s_nxt.pulse = sigIn & ~s_r.prev;
			EDGE_FALL: s_nxt.pulse = ~sigIn & s_r.prev;
			EDGE_BOTH: s_nxt.pulse = sigIn ^ s_r.prev;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pulse = s_r.pulse;

endmodule

// ==== rtl/cmp_cap_slot.sv ====
`timescale 1ns/10ps
module cmp_cap_slot
	import timer_q_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic wrEn,
	input wire logic [15:0] wrData,
	input wire logic anytime,
	input wire logic batchLoad,
	input wire logic capEn,
	input wire logic [15:0] capData,
	input wire logic capClr,
	output logic [15:0] regVal,
	output logic [15:0] bufVal
);

	typedef struct packed {
		logic [15:0] regv;
		logic [15:0] bufv;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (batchLoad) begin
			s_nxt.bufv = s_r.regv;
		end
		// capture beats a same-cycle write so the stored count is never torn
		if (capEn) begin
			s_nxt.regv = capData;
		end else if (capClr) begin
			s_nxt.regv = CMP_RESET;
		end else if (wrEn) begin
			s_nxt.regv = wrData;
			if (anytime) begin
				s_nxt.bufv = wrData;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign regVal = s_r.regv;
	assign bufVal = s_r.bufv;

endmodule

// ==== rtl/timer_q_capture_compare_output.sv ====
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
// How it works
// - compare register one accepts writes while the counter runs
// - register one value goes to its buffer; counter equal buffer raises irq one
// - match on register one with output enabled inverts pin one and its twin in free-run without capture; in triggered and PWM modes it ends their pulse
// - unit one has no register-one pins; its match only raises the irq
// - stopping the counter leaves compare register contents unchanged, apart from the capture register
// - capture exists only in unit zero and only on register one
// - free-running capture stores the counter on a valid capture edge
// - pulse-width mode stores the counter and clears it on the same edge
// - a read colliding with a capture still returns a coherent value
// - stopping the counter clears the capture register
// - write method per mode: anytime, batch, or none in pulse-width mode
// - in batch modes a write to register one while the counter runs arms the buffer transfer
// - triggered modes start by software only; extra modes exist in unit zero only
// - interval: output zero toggles; external trigger: zero toggles, others pulse
// - free-run toggles on compare; one-shot and PWM: zero toggles, others pulse; event and width drive none
// - hi-z outputs follow pulse outputs and float on a shutoff edge
// - clock failure with output zero selected forces it low until reset
// - batch values load into buffers at the next counter clear
// - disabled pin holds its level bit; an enabled pin that the mode uses flips once counting starts
module timer_q_capture_compare_output
	import timer_q_pkg::*;
#(
	parameter bit UNIT_ZERO = 1'b1,
	parameter int ADDR_W = 8
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic captureInOne,
	input wire logic eventIn,
	input wire logic hizShutoffIn,
	input wire logic clockFailIn,
	output logic pulseOutZero,
	output logic pulseOutOne,
	output logic pulseOutTwo,
	output logic pulseOutThree,
	output logic hizPulseOutOne,
	output logic hizPulseOutTwo,
	output logic hizPulseOutThree,
	output logic hizOeOne,
	output logic hizOeTwo,
	output logic hizOeThree,
	output logic matchIrqZero,
	output logic matchIrqOne,
	output logic matchIrqTwo,
	output logic matchIrqThree,
	output logic clockFailLowOut
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic isTrigMode(input mode_t m);
		return (m == MODE_EXTTRIG) || (m == MODE_ONESHOT);
	endfunction

	function automatic logic isBatchMode(input mode_t m);
		return (m == MODE_EXTTRIG) || (m == MODE_PWM);
	endfunction

	function automatic logic modeLegal(input logic [2:0] m);
		logic ok;
		ok = (m != 3'b111);
		if (!UNIT_ZERO) begin
			ok = (m == MODE_INTERVAL) || (m == MODE_FREERUN);
		end
		return ok;
	endfunction

	function automatic logic cmpHit(input logic [7:0] a, input int idx);
		return a == 8'(CMP0_OFS + 8'(idx) * CMP_STEP);
	endfunction

	function automatic logic outUsed(input mode_t m, input int idx, input logic capSel);
		logic u;
		u = 1'b0;
		unique case (m)
			MODE_INTERVAL: u = (idx == 0);
			MODE_EXTTRIG, MODE_ONESHOT, MODE_PWM: u = 1'b1;
			MODE_FREERUN: u = !((idx == 1) && capSel);
			MODE_EVENT, MODE_PULSEWIDTH: u = 1'b0;
			default: u = 1'b0;
		endcase
		return u;
	endfunction

	typedef struct packed {
		logic run;
		logic prevRun;
		mode_t mode;
		logic capSel;
		edge_sel_t capEdge;
		edge_sel_t evtEdge;
		edge_sel_t offEdge;
		logic [3:0] gate;
		logic [3:0] level;
		logic zeroSel;
		logic started;
		logic armed;
		logic [15:0] cnt;
		logic [3:0] tgl;
		logic hizOff;
		logic clkFail;
		logic [3:0] pout;
		logic [2:0] hiz;
		logic [2:0] hizOe;
		logic [3:0] irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	logic [15:0] cmpReg [CMP_NUM];
	logic [15:0] cmpBuf [CMP_NUM];
	logic [CMP_NUM-1:0] cmpWr;
	logic capPulse;
	logic evtPulse;
	logic offPulse;
	logic setup;
	logic wrAcc;
	logic capUse;
	logic capEn;
	logic capClr;
	logic anytime;
	logic clearEvt;
	logic cntEn;
	logic [CMP_NUM-1:0] match;
	logic [7:0] addr;

	assign addr = 8'(paddr);
	assign setup = psel && !penable;
	assign wrAcc = psel && penable && pwrite;

	// ****************************************
	// input edges
	// ****************************************
	edge_pulse capEdgeDet (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.sigIn(captureInOne),
		.edgeSel(s_r.capEdge),
		.pulse(capPulse)
	);

	edge_pulse evtEdgeDet (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.sigIn(eventIn),
		.edgeSel(s_r.evtEdge),
		.pulse(evtPulse)
	);

	edge_pulse offEdgeDet (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.sigIn(hizShutoffIn),
		.edgeSel(s_r.offEdge),
		.pulse(offPulse)
	);

	// ****************************************
	// compare and capture slots
	// ****************************************
	assign capUse = UNIT_ZERO && ((s_r.mode == MODE_PULSEWIDTH) ||
		((s_r.mode == MODE_FREERUN) && s_r.capSel));
	assign capEn = capUse && s_r.started && capPulse;
	assign capClr = capUse && s_r.prevRun && !s_r.run;
	// while stopped, batch modes write straight through to the buffer
	assign anytime = !isBatchMode(s_r.mode) || !s_r.run;

	genvar gi;
	generate
		for (gi = 0; gi < CMP_NUM; gi++) begin : gSlot
			// writes ignored in pulse-width mode, taken regardless of run
			assign cmpWr[gi] = wrAcc && cmpHit(addr, gi) &&
				(s_r.mode != MODE_PULSEWIDTH);
			cmp_cap_slot slot (
				.core_clk(core_clk),
				.arst_n(arst_n),
				.wrEn(cmpWr[gi]),
				.wrData(pwdata[15:0]),
				.anytime(anytime),
				.batchLoad(s_r.armed && clearEvt && isBatchMode(s_r.mode)),
				.capEn((gi == 1) && capEn),
				.capData(s_r.cnt),
				.capClr((gi == 1) && capClr),
				.regVal(cmpReg[gi]),
				.bufVal(cmpBuf[gi])
			);
			assign match[gi] = s_r.started && (s_r.cnt == cmpBuf[gi]);
		end
	endgenerate

	assign cntEn = s_r.started && ((s_r.mode != MODE_EVENT) || evtPulse);
	always_comb begin
		clearEvt = 1'b0;
		if (s_r.mode == MODE_PULSEWIDTH) begin
			clearEvt = capEn;
		end else if (s_r.mode == MODE_FREERUN) begin
			clearEvt = cntEn && (s_r.cnt == CNT_IDLE);
		end else begin
			clearEvt = cntEn && match[0];
		end
	end

	// ****************************************
	// state update
	// ****************************************
	always_comb begin
		logic trig;
		logic [31:0] wd;
		trig = 1'b0;
		wd = pwdata;
		s_nxt = s_r;
		s_nxt.irq = 4'h0;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		s_nxt.prevRun = s_r.run;
		// read data latched in setup: one coherent snapshot of each word
		if (setup) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = RDATA_RESET;
			case (addr)
				CTRL_OFS: s_nxt.prdata = {20'h0_0000, s_r.offEdge, s_r.evtEdge,
					s_r.capEdge, s_r.capSel, 1'b0, s_r.mode, s_r.run};
				IOC_OFS: s_nxt.prdata = {23'h00_0000, s_r.zeroSel, s_r.level, s_r.gate};
				CMP0_OFS: s_nxt.prdata = {16'h0000, cmpReg[0]};
				8'(CMP0_OFS + CMP_STEP): s_nxt.prdata = {16'h0000, cmpReg[1]};
				8'(CMP0_OFS + 8'h08): s_nxt.prdata = {16'h0000, cmpReg[2]};
				8'(CMP0_OFS + 8'h0C): s_nxt.prdata = {16'h0000, cmpReg[3]};
				COUNT_OFS: s_nxt.prdata = {16'h0000, s_r.cnt};
				STATUS_OFS: s_nxt.prdata = {29'h0000_0000, s_r.armed, s_r.clkFail,
					s_r.hizOff};
				default: s_nxt.pslverr = 1'b1;
			endcase
		end
		if (wrAcc && (addr == CTRL_OFS)) begin
			s_nxt.run = wd[CTRL_RUN_BIT];
			// mode and edges only change while stopped
			if (!s_r.run) begin
				if (modeLegal(wd[CTRL_MODE_LSB +: 3])) begin
					s_nxt.mode = mode_t'(wd[CTRL_MODE_LSB +: 3]);
				end
				s_nxt.capSel = UNIT_ZERO && wd[CTRL_CAPSEL_BIT];
				s_nxt.capEdge = edge_sel_t'(wd[CTRL_CAPEDGE_LSB +: 2]);
				s_nxt.evtEdge = edge_sel_t'(wd[CTRL_EVTEDGE_LSB +: 2]);
				s_nxt.offEdge = edge_sel_t'(wd[CTRL_OFFEDGE_LSB +: 2]);
			end
			trig = wd[CTRL_TRIG_BIT] && s_r.run && isTrigMode(s_r.mode);
		end
		if (wrAcc && (addr == IOC_OFS)) begin
			s_nxt.gate = wd[IOC_GATE_LSB +: 4];
			s_nxt.level = wd[IOC_LEVEL_LSB +: 4];
			s_nxt.zeroSel = wd[IOC_ZEROSEL_BIT];
		end
		// batch arming: a new arm in the load cycle survives the load
		if (s_r.armed && clearEvt) begin
			s_nxt.armed = 1'b0;
		end
		if (cmpWr[1] && isBatchMode(s_r.mode) && s_r.run) begin
			s_nxt.armed = 1'b1;
		end
		if (!s_r.run) begin
			s_nxt.started = 1'b0;
			s_nxt.cnt = CNT_IDLE;
			s_nxt.tgl = 4'h0;
			s_nxt.armed = 1'b0;
		end else if (!s_r.prevRun && !isTrigMode(s_r.mode)) begin
			s_nxt.started = 1'b1;
			s_nxt.cnt = CNT_ZERO;
			s_nxt.tgl = 4'hF;
		end else if (trig) begin
			s_nxt.started = 1'b1;
			s_nxt.cnt = CNT_ZERO;
			s_nxt.tgl = {3'b111, s_r.started ? ~s_r.tgl[0] : 1'b1};
		end else if (s_r.started) begin
			if (clearEvt) begin
				s_nxt.cnt = CNT_ZERO;
			end else if (cntEn) begin
				s_nxt.cnt = 16'(s_r.cnt + CNT_ONE);
			end
			// one request per counted step, never a level
			s_nxt.irq[0] = cntEn && match[0] && !capUse;
			s_nxt.irq[1] = (cntEn && match[1] && !capUse) || capEn;
			s_nxt.irq[2] = cntEn && match[2];
			s_nxt.irq[3] = cntEn && match[3];
			if (cntEn && match[0]) begin
				s_nxt.tgl[0] = ~s_r.tgl[0];
			end
			for (int b = 1; b < CMP_NUM; b++) begin
				if (s_r.mode == MODE_FREERUN) begin
					if (cntEn && match[b]) begin
						s_nxt.tgl[b] = ~s_r.tgl[b];
					end
				end else if (cntEn && match[b]) begin
					s_nxt.tgl[b] = 1'b0;
				end else if (clearEvt) begin
					s_nxt.tgl[b] = 1'b1;
				end
			end
			if ((s_r.mode == MODE_ONESHOT) && cntEn && match[0]) begin
				s_nxt.started = 1'b0;
				s_nxt.cnt = CNT_IDLE;
			end
		end
		// ****************************************
		// pins
		// ****************************************
		if (clockFailIn && s_r.zeroSel) begin
			s_nxt.clkFail = 1'b1;
		end
		if (offPulse && UNIT_ZERO) begin
			s_nxt.hizOff = 1'b1;
		end else if (!s_r.run) begin
			s_nxt.hizOff = 1'b0;
		end
		for (int i = 0; i < CMP_NUM; i++) begin
			s_nxt.pout[i] = (s_nxt.gate[i] && outUsed(s_nxt.mode, i, s_nxt.capSel)) ?
				(s_nxt.level[i] ^ s_nxt.tgl[i]) : s_nxt.level[i];
		end
		if (!UNIT_ZERO) begin
			s_nxt.pout[3:1] = 3'b000;
		end
		if (s_nxt.clkFail) begin
			s_nxt.pout[0] = 1'b0;
		end
		s_nxt.hiz = s_nxt.pout[3:1];
		s_nxt.hizOe = (UNIT_ZERO && !s_nxt.hizOff) ? 3'b111 : 3'b000;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign pulseOutZero = s_r.pout[0];
	assign pulseOutOne = s_r.pout[1];
	assign pulseOutTwo = s_r.pout[2];
	assign pulseOutThree = s_r.pout[3];
	assign hizPulseOutOne = s_r.hiz[0];
	assign hizPulseOutTwo = s_r.hiz[1];
	assign hizPulseOutThree = s_r.hiz[2];
	assign hizOeOne = s_r.hizOe[0];
	assign hizOeTwo = s_r.hizOe[1];
	assign hizOeThree = s_r.hizOe[2];
	assign matchIrqZero = s_r.irq[0];
	assign matchIrqOne = s_r.irq[1];
	assign matchIrqTwo = s_r.irq[2];
	assign matchIrqThree = s_r.irq[3];
	assign clockFailLowOut = s_r.clkFail;

endmodule

// ==== verification/tq_cco_monitor.sv ====
`timescale 1ns/10ps
module tq_cco_monitor
	import timer_q_pkg::*;
#(
	parameter bit UNIT_ZERO = 1'b1,
	parameter int ADDR_W = 8
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pulseOutZero,
	input wire logic pulseOutOne,
	input wire logic pulseOutTwo,
	input wire logic pulseOutThree,
	input wire logic hizPulseOutOne,
	input wire logic hizPulseOutTwo,
	input wire logic hizPulseOutThree,
	input wire logic hizOeOne,
	input wire logic matchIrqZero,
	input wire logic matchIrqOne,
	input wire logic matchIrqTwo,
	input wire logic matchIrqThree,
	input wire logic clockFailLowOut
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	property p_setup_ready;
		psel && !penable |=> pready;
	endproperty
	a_setup_ready: assert property (p_setup_ready)
		else $error("access cycle without ready");
	property p_hiz_follow;
		{hizPulseOutOne, hizPulseOutTwo, hizPulseOutThree} ==
			{pulseOutOne, pulseOutTwo, pulseOutThree};
	endproperty
	a_hiz_follow: assert property (p_hiz_follow)
		else $error("hi-z outputs differ from pulse outputs");
	property p_unit_pins;
		(pulseOutOne || hizOeOne) |-> UNIT_ZERO == 1'b1;
	endproperty
	a_unit_pins: assert property (p_unit_pins)
		else $error("unit one drives a register-one pin");
	property p_fail_hold;
		clockFailLowOut |=> clockFailLowOut [*3];
	endproperty
	a_fail_hold: assert property (p_fail_hold)
		else $error("clock fail latch released");
	property p_fail_low;
		clockFailLowOut |-> !pulseOutZero;
	endproperty
	a_fail_low: assert property (p_fail_low)
		else $error("output zero not forced low");
	property p_irq_one;
		matchIrqOne |=> !matchIrqOne;
	endproperty
	a_irq_one: assert property (p_irq_one)
		else $error("irq one wider than a cycle");
	property p_irq_zero;
		$rose(matchIrqZero) |=> $fell(matchIrqZero);
	endproperty
	a_irq_zero: assert property (p_irq_zero)
		else $error("irq zero wider than a cycle");
	property p_irq_two;
		matchIrqTwo |=> !matchIrqTwo;
	endproperty
	a_irq_two: assert property (p_irq_two)
		else $error("irq two wider than a cycle");
	property p_irq_three;
		matchIrqThree ##1 matchIrqThree |-> 1'b0;
	endproperty
	a_irq_three: assert property (p_irq_three)
		else $error("irq three wider than a cycle");
endmodule

bind timer_q_capture_compare_output tq_cco_monitor #(.UNIT_ZERO(UNIT_ZERO), .ADDR_W(ADDR_W))
	u_tq_cco_monitor (.core_clk, .arst_n, .psel, .penable, .pready, .pulseOutZero,
	.pulseOutOne, .pulseOutTwo, .pulseOutThree, .hizPulseOutOne, .hizPulseOutTwo,
	.hizPulseOutThree, .hizOeOne, .matchIrqZero, .matchIrqOne, .matchIrqTwo,
	.matchIrqThree, .clockFailLowOut);

// ==== verification/far_side_model.sv ====
`timescale 1ns/10ps
module far_side_model (
	input wire logic core_clk,
	output logic captureInOne,
	output logic hizShutoffIn,
	output logic clockFailIn
);
	initial begin
		captureInOne = 1'b0;
		hizShutoffIn = 1'b0;
		clockFailIn = 1'b0;
	end
	// lines drop on their own, so the caller can watch the reaction meanwhile
	task automatic raise(input int line);
		case (line)
			0: captureInOne <= 1'b1;
			1: hizShutoffIn <= 1'b1;
			default: clockFailIn <= 1'b1;
		endcase
		fork
			begin
				repeat (4) @(posedge core_clk);
				if (line == 0) captureInOne <= 1'b0;
				else if (line == 1) hizShutoffIn <= 1'b0;
				else clockFailIn <= 1'b0;
			end
		join_none
	endtask
endmodule

// ==== verification/tb_timer_q_capture_compare_output.sv ====
`timescale 1ns/10ps
module tb_timer_q_capture_compare_output
	import timer_q_pkg::*;
;
	localparam logic [7:0] CMP1_A = CMP0_OFS + CMP_STEP;
	localparam logic [7:0] CMP2_A = CMP1_A + CMP_STEP;
	logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, err, eventIn;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic captureInOne, hizShutoffIn, clockFailIn, clockFailLowOut;
	logic pulseOutZero, pulseOutOne, pulseOutTwo, pulseOutThree;
	logic hizPulseOutOne, hizPulseOutTwo, hizPulseOutThree, hizOeOne, hizOeTwo, hizOeThree;
	logic matchIrqZero, matchIrqOne, matchIrqTwo, matchIrqThree;
	int n_fail, samples_checked, cyc;

	timer_q_capture_compare_output u_timer_q_capture_compare_output (.core_clk, .arst_n,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.captureInOne, .eventIn, .hizShutoffIn, .clockFailIn, .pulseOutZero, .pulseOutOne,
		.pulseOutTwo, .pulseOutThree, .hizPulseOutOne, .hizPulseOutTwo, .hizPulseOutThree,
		.hizOeOne, .hizOeTwo, .hizOeThree, .matchIrqZero, .matchIrqOne, .matchIrqTwo,
		.matchIrqThree, .clockFailLowOut);
	far_side_model u_far_side_model (.core_clk, .captureInOne, .hizShutoffIn, .clockFailIn);

	// ****************************************
	// clock, timeout, helpers
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask
	// idle edge at the end keeps a back-to-back call from re-driving psel in one step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask
	task automatic waitIrq(input logic one);
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while ((one ? matchIrqOne : matchIrqZero) !== 1'b1 && n < 200);
		check(n < 200, 1'b1);
	endtask

	// ****************************************
	// tests
	// ****************************************
	initial begin
		arst_n = 1'b0;
		{psel, penable, pwrite, eventIn} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		{n_fail, samples_checked} = {32'd0, 32'd0};
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rdChk(CMP1_A, 32'h0000_0000);
		apb(1'b0, 8'h20, 32'h0000_0000);
		check(err, 1'b1);
		$display("test reset done");
		wr(IOC_OFS, 32'h0000_0003);
		wr(CMP0_OFS, 32'h0000_0009);
		wr(CMP1_A, 32'h0000_0003);
		wr(CTRL_OFS, 32'h0000_0001);
		waitIrq(1'b0);
		check({pulseOutZero, pulseOutOne}, 2'b00);
		waitIrq(1'b0);
		check(pulseOutZero, 1'b1);
		wr(CMP1_A, 32'h0000_0005);
		rdChk(CMP1_A, 32'h0000_0005);
		waitIrq(1'b1);
		wr(CTRL_OFS, 32'h0000_0000);
		rdChk(CMP1_A, 32'h0000_0005);
		$display("test interval done");
		wr(IOC_OFS, 32'h0000_0002);
		wr(CMP1_A, 32'h0000_0010);
		wr(CTRL_OFS, 32'h0000_000B);
		repeat (4) @(posedge core_clk);
		check(pulseOutOne, 1'b1);
		waitIrq(1'b1);
		check(pulseOutOne, 1'b0);
		wr(CTRL_OFS, 32'h0000_006A);
		wr(CTRL_OFS, 32'h0000_006B);
		repeat (30) @(posedge core_clk);
		u_far_side_model.raise(0);
		waitIrq(1'b1);
		apb(1'b0, CMP1_A, 32'h0000_0000);
		check(rd >= 32'h0000_001E && rd < 32'h0000_0032, 1'b1);
		wr(CTRL_OFS, 32'h0000_006A);
		rdChk(CMP1_A, 32'h0000_0000);
		$display("test free-run done");
		wr(CTRL_OFS, 32'h0000_006C);
		wr(CMP2_A, 32'h0000_1234);
		rdChk(CMP2_A, 32'h0000_0000);
		wr(CTRL_OFS, 32'h0000_006D);
		repeat (30) @(posedge core_clk);
		u_far_side_model.raise(0);
		waitIrq(1'b1);
		apb(1'b0, COUNT_OFS, 32'h0000_0000);
		check(rd < 32'h0000_0008, 1'b1);
		apb(1'b0, CMP1_A, 32'h0000_0000);
		check(rd >= 32'h0000_001E && rd < 32'h0000_0032, 1'b1);
		wr(CTRL_OFS, 32'h0000_006C);
		$display("test pulse-width done");
		// PWM mode and a rising shutoff edge chosen first, while stopped
		wr(IOC_OFS, 32'h0000_000F);
		wr(CTRL_OFS, 32'h0000_0408);
		// compare writes are dropped in pulse-width mode, so leave it first
		wr(CMP0_OFS, 32'h0000_0014);
		wr(CTRL_OFS, 32'h0000_0409);
		check(hizOeOne, 1'b1);
		wr(CMP2_A, 32'h0000_000C);
		rdChk(STATUS_OFS, 32'h0000_0000);
		wr(CMP1_A, 32'h0000_0005);
		rdChk(STATUS_OFS, 32'h0000_0004);
		waitIrq(1'b0);
		check({pulseOutOne, pulseOutTwo, pulseOutThree}, 3'b111);
		repeat (8) @(posedge core_clk);
		check({pulseOutOne, pulseOutTwo, pulseOutThree}, 3'b010);
		rdChk(STATUS_OFS, 32'h0000_0000);
		u_far_side_model.raise(1);
		repeat (5) @(posedge core_clk);
		check({hizOeOne, hizOeTwo, hizOeThree}, 3'b000);
		rdChk(STATUS_OFS, 32'h0000_0001);
		wr(CTRL_OFS, 32'h0000_0408);
		$display("test pwm done");
		wr(CMP0_OFS, 32'h0000_0003);
		wr(CTRL_OFS, 32'h0000_0007);
		rdChk(COUNT_OFS, 32'h0000_FFFF);
		wr(CTRL_OFS, 32'h0000_0017);
		waitIrq(1'b0);
		rdChk(COUNT_OFS, 32'h0000_FFFF);
		wr(CTRL_OFS, 32'h0000_0000);
		$display("test one-shot done");
		wr(IOC_OFS, 32'h0000_0101);
		wr(CMP0_OFS, 32'h0000_0003);
		wr(CTRL_OFS, 32'h0000_0001);
		u_far_side_model.raise(2);
		repeat (10) @(posedge core_clk);
		check({clockFailLowOut, pulseOutZero}, 2'b10);
		rdChk(STATUS_OFS, 32'h0000_0002);
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		check(clockFailLowOut, 1'b0);
		$display("test clock fail done");
		stop_test();
	end
endmodule
